/* File: core/rcp_pkg.sv */
package rcp_pkg;
    localparam int PIX_W = 10;
    localparam int RGB_W = 12;
    localparam int LINE_LEN = 1600;
    localparam int NREG = 24;
    // register indices, byte address = 4 * index
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_BLACK = 5'h01;
    localparam logic [4:0] REG_GAIN = 5'h02;
    localparam logic [4:0] REG_SHX = 5'h03;
    localparam logic [4:0] REG_SHY = 5'h04;
    localparam logic [4:0] REG_KX0 = 5'h05;
    localparam logic [4:0] REG_KY0 = 5'h08;
    localparam logic [4:0] REG_DEFTHR = 5'h0B;
    localparam logic [4:0] REG_EDGETHR = 5'h0C;
    localparam logic [4:0] REG_CCM0 = 5'h0D;
    localparam logic [4:0] REG_APER = 5'h16;
    localparam logic [4:0] REG_STATUS = 5'h17;
    localparam int CTRL_TP_LSB = 0;
    localparam int CTRL_AWB_BIT = 2;
    localparam int STAT_AWB_BIT = 8;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'h0040;
    localparam logic [15:0] RST_SHX = 16'h0320;
    localparam logic [15:0] RST_SHY = 16'h0258;
    localparam logic [15:0] RST_THR = 16'h0040;
    localparam logic [15:0] RST_UNIT = 16'h0100;
    localparam logic [9:0] TP_FLAT_LVL = 10'h200;
    localparam logic [11:0] AWB_UP = 12'h120;
    localparam logic [11:0] AWB_DN = 12'h0E0;
    typedef enum logic [1:0] {
        TP_LIVE  = 2'b00,
        TP_FLAT  = 2'b01,
        TP_RAMP  = 2'b10,
        TP_CHECK = 2'b11
    } rcp_tp_t;
    typedef struct packed {
        logic       fv;
        logic       lv;
        logic       vld;
        logic [9:0] pix;
    } rcp_sensor_t;
    typedef struct packed {
        logic        fv;
        logic        lv;
        logic        vld;
        logic [10:0] col;
        logic [10:0] row;
        logic [9:0]  pix;
    } rcp_raw_t;
    typedef struct packed {
        logic        fv;
        logic        lv;
        logic        vld;
        logic [11:0] r;
        logic [11:0] g;
        logic [11:0] b;
    } rcp_rgb_t;
endpackage

/* File: core/rcp_pipeline.sv */
`timescale 1ns/1ps
// Operation
// - test mode swaps live input for patterns
// - black level subtract then digital gain
// - shading factor, piecewise quadratic, per color
// - line memories give simultaneous neighbour lines
// - defective pixels replaced by same-color average
// - input is one 10-bit mosaic sample
// - one sample until defect, then RGB
// - edge-aware interpolation, smooth only flat areas
// - three-by-three matrix, sums of three products
// - twelve bits per channel after matrix
// - matrix from user or auto white balance
// - same sharpening on all three channels
module rcp_pipeline (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [6:0]         adr_i,
    input  wire logic [1:0]         sel_i,
    input  wire logic [15:0]        dat_i,
    output logic      [15:0]        dat_o,
    output logic                    ack_o,
    input  wire rcp_pkg::rcp_sensor_t sensorIn,
    output rcp_pkg::rcp_rgb_t       rgbOut
);
    import rcp_pkg::*;

    logic [15:0] regs_q [NREG];
    logic [15:0] rdData;
    logic [7:0]  frameCnt_q;
    logic        awbWarm_q;
    wire  [4:0]  regIdx = adr_i[6:2];
    wire         wbReq = cyc_i & stb_i & ~ack_o;

    function automatic logic [15:0] rstVal(input int i);
        if (i == REG_GAIN) return RST_GAIN;
        else if (i == REG_SHX) return RST_SHX;
        else if (i == REG_SHY) return RST_SHY;
        else if (i == REG_DEFTHR || i == REG_EDGETHR) return RST_THR;
        else if (i == REG_CCM0 || i == REG_CCM0 + 4 || i == REG_CCM0 + 8) return RST_UNIT;
        else return RST_ZERO;
    endfunction

    // the status word is hardware owned; writes to it are dropped
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        wire hit = wbReq & we_i & (regIdx == 5'(i)) & (i != REG_STATUS);
        always_ff @(posedge clk) begin
            if (reset)
                regs_q[i] <= rstVal(i);
            else if (hit) begin
                if (sel_i[0]) regs_q[i][7:0] <= dat_i[7:0];
                if (sel_i[1]) regs_q[i][15:8] <= dat_i[15:8];
            end
        end
    end

    // unmapped indices answer with zero
    assign rdData = (regIdx == REG_STATUS) ? {7'h00, awbWarm_q, frameCnt_q}
                  : (regIdx < 5'(NREG)) ? regs_q[regIdx] : 16'h0000;

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_o <= 1'b0;
            dat_o <= 16'h0000;
        end else begin
            ack_o <= wbReq;
            dat_o <= wbReq ? rdData : 16'h0000;
        end
    end

    wire rcp_tp_t tpMode = rcp_tp_t'(regs_q[REG_CTRL][CTRL_TP_LSB +: 2]);
    wire          awbEn = regs_q[REG_CTRL][CTRL_AWB_BIT];
    wire [9:0]    black = regs_q[REG_BLACK][9:0];
    wire [7:0]    gain = regs_q[REG_GAIN][7:0];

    // position counters for the incoming mosaic
    logic [10:0] col_q, row_q;
    logic        lvPrev_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            col_q <= 11'h000;
            row_q <= 11'h000;
            lvPrev_q <= 1'b0;
        end else begin
            lvPrev_q <= sensorIn.lv;
            if (!sensorIn.lv) col_q <= 11'h000;
            else if (sensorIn.vld) col_q <= col_q + 11'h001;
            if (!sensorIn.fv) row_q <= 11'h000;
            else if (lvPrev_q && !sensorIn.lv) row_q <= row_q + 11'h001;
        end
    end

    // stage 0: pattern substitution
    logic [9:0] tpPix;
    always_comb begin
        case (tpMode)
            TP_FLAT:  tpPix = TP_FLAT_LVL;
            TP_RAMP:  tpPix = col_q[9:0];
            TP_CHECK: tpPix = {10{col_q[4] ^ row_q[4]}};
            default:  tpPix = sensorIn.pix;
        endcase
    end
    rcp_raw_t s0_q, s1_q, s2_q, s3_q, s4_q;
    always_ff @(posedge clk) begin
        if (reset) s0_q <= '0;
        else s0_q <= {sensorIn.fv, sensorIn.lv, sensorIn.vld, col_q, row_q, tpPix};
    end

    // stage 1: black level then gain, gain is 2.6 fixed point
    wire [9:0]  blk = (s0_q.pix > black) ? s0_q.pix - black : 10'h000;
    wire [17:0] gProd = blk * gain;
    wire [9:0]  gPix = (gProd[17:16] != 2'b00) ? 10'h3FF : gProd[15:6];
    always_ff @(posedge clk) begin
        if (reset) s1_q <= '0;
        else s1_q <= {s0_q[34:10], gPix};
    end

    // stage 2: shading; squared distance saturates past the knee
    wire [1:0]  clr = (s1_q.row[0] & s1_q.col[0]) ? 2'd2 : {1'b0, s1_q.row[0] ^ s1_q.col[0]};
    wire [10:0] cx = regs_q[REG_SHX][10:0];
    wire [10:0] cy = regs_q[REG_SHY][10:0];
    wire [10:0] dx = (s1_q.col >= cx) ? s1_q.col - cx : cx - s1_q.col;
    wire [10:0] dy = (s1_q.row >= cy) ? s1_q.row - cy : cy - s1_q.row;
    wire [21:0] dx2 = dx * dx;
    wire [21:0] dy2 = dy * dy;
    wire [9:0]  dxq = (dx2[21:20] != 2'b00) ? 10'h3FF : dx2[19:10];
    wire [9:0]  dyq = (dy2[21:20] != 2'b00) ? 10'h3FF : dy2[19:10];
    wire [7:0]  kx = regs_q[REG_KX0 + 5'(clr)][7:0];
    wire [7:0]  ky = regs_q[REG_KY0 + 5'(clr)][7:0];
    wire [18:0] fSum = 19'(kx * dxq) + 19'(ky * dyq);
    wire [11:0] fac = 12'h400 + {1'b0, fSum[18:8]};
    wire [21:0] sProd = s1_q.pix * fac;
    wire [9:0]  sPix = (sProd[21:20] != 2'b00) ? 10'h3FF : sProd[19:10];
    always_ff @(posedge clk) begin
        if (reset) s2_q <= '0;
        else s2_q <= {s1_q[34:10], sPix};
    end

    // stage 3: two line memories, window lags one line and two pixels
    logic [9:0] lineA [LINE_LEN];
    logic [9:0] lineB [LINE_LEN];
    logic [9:0] rdA_q, rdB_q;
    always_ff @(posedge clk) begin
        if (s2_q.vld && s2_q.col < 11'(LINE_LEN)) begin
            rdA_q <= lineA[s2_q.col];
            rdB_q <= lineB[s2_q.col];
            lineA[s2_q.col] <= s2_q.pix;
            lineB[s2_q.col] <= lineA[s2_q.col];
        end
    end
    always_ff @(posedge clk) begin
        if (reset) s3_q <= '0;
        else s3_q <= s2_q;
    end

    logic [9:0] win_q [3][5];
    wire  [9:0] winIn [3];
    // top lines of a frame reuse the nearest written line, so uncleared memory never reaches the window
    assign winIn[1] = (s3_q.row == 11'h000) ? s3_q.pix : rdA_q;
    assign winIn[0] = (s3_q.row < 11'h002) ? winIn[1] : rdB_q;
    assign winIn[2] = s3_q.pix;
    for (genvar r = 0; r < 3; r++) begin : g_win
        always_ff @(posedge clk) begin
            if (reset) win_q[r] <= '{default: 10'h000};
            else if (s3_q.vld) win_q[r] <= '{win_q[r][1], win_q[r][2], win_q[r][3],
                                           win_q[r][4], winIn[r]};
        end
    end
    always_ff @(posedge clk) begin
        if (reset) s4_q <= '0;
        else s4_q <= {s3_q.fv, s3_q.lv, s3_q.vld, s3_q.col - 11'h002, s3_q.row - 11'h001,
                      s3_q.pix};
    end

    // defect: compare centre with same-color horizontal neighbours
    wire [9:0]  ctr = win_q[1][2];
    wire [9:0]  nbA = win_q[1][0];
    wire [9:0]  nbB = win_q[1][4];
    wire [9:0]  dThr = regs_q[REG_DEFTHR][9:0];
    wire [10:0] nbMax = {1'b0, (nbA > nbB) ? nbA : nbB};
    wire [10:0] nbMin = {1'b0, (nbA > nbB) ? nbB : nbA};
    wire [10:0] defAvgW = nbA + nbB;
    wire [9:0]  defAvg = defAvgW[10:1];
    wire        hot = {1'b0, ctr} > nbMax + {1'b0, dThr};
    wire        dark = {1'b0, ctr} + {1'b0, dThr} < nbMin;
    wire        defFix = hot | dark;
    wire [9:0]  ctrFixed = defFix ? defAvg : ctr;

    // interpolation on the 3x3 core around the corrected centre
    wire [9:0]  pN = win_q[0][2], pS = win_q[2][2], pW = win_q[1][1], pE = win_q[1][3];
    wire [11:0] diagSum = win_q[0][1] + win_q[0][3] + win_q[2][1] + win_q[2][3];
    wire [11:0] crossSum = pN + pS + pW + pE;
    wire [10:0] hSum = pW + pE;
    wire [10:0] vSum = pN + pS;
    wire [9:0]  gH = (pW > pE) ? pW - pE : pE - pW;
    wire [9:0]  gV = (pN > pS) ? pN - pS : pS - pN;
    wire [10:0] eThr = {1'b0, regs_q[REG_EDGETHR][9:0]};
    wire        useH = ({1'b0, gH} + eThr) < {1'b0, gV};
    wire        useV = ({1'b0, gV} + eThr) < {1'b0, gH};
    wire [9:0]  gEst = useH ? hSum[10:1] : useV ? vSum[10:1] : crossSum[11:2];
    wire        rOdd = s4_q.row[0];
    wire        cOdd = s4_q.col[0];
    wire        atR = ~rOdd & ~cOdd;
    wire        atB = rOdd & cOdd;
    logic [9:0] iR, iG, iB;
    always_comb begin
        if (atR) begin
            iR = ctrFixed;
            iG = gEst;
            iB = diagSum[11:2];
        end else if (atB) begin
            iR = diagSum[11:2];
            iG = gEst;
            iB = ctrFixed;
        end else begin
            iG = ctrFixed;
            iR = rOdd ? vSum[10:1] : hSum[10:1];
            iB = rOdd ? hSum[10:1] : vSum[10:1];
        end
    end
    rcp_rgb_t s5_q, s6_q;
    always_ff @(posedge clk) begin
        if (reset) s5_q <= '0;
        else s5_q <= {s4_q.fv, s4_q.lv, s4_q.vld, 2'b00, iR, 2'b00, iG, 2'b00, iB};
    end

    // auto white balance: per-frame red/blue totals pick the matrix
    logic [31:0] sumR_q, sumB_q;
    logic        fvPrev_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            sumR_q <= 32'h0;
            sumB_q <= 32'h0;
            fvPrev_q <= 1'b0;
            awbWarm_q <= 1'b0;
            frameCnt_q <= 8'h00;
        end else begin
            fvPrev_q <= s5_q.fv;
            if (fvPrev_q && !s5_q.fv) begin
                awbWarm_q <= sumR_q > sumB_q;
                frameCnt_q <= frameCnt_q + 8'h01;
                sumR_q <= 32'h0;
                sumB_q <= 32'h0;
            end else if (s5_q.vld) begin
                sumR_q <= sumR_q + 32'(s5_q.r);
                sumB_q <= sumB_q + 32'(s5_q.b);
            end
        end
    end

    // colour matrix, coefficients signed with 8 fraction bits
    wire [11:0] autoR = awbWarm_q ? AWB_DN : AWB_UP;
    wire [11:0] autoB = awbWarm_q ? AWB_UP : AWB_DN;
    wire [11:0] inCh [3];
    assign inCh[0] = s5_q.r;
    assign inCh[1] = s5_q.g;
    assign inCh[2] = s5_q.b;
    logic [11:0] ccmOut [3];
    for (genvar o = 0; o < 3; o++) begin : g_ccm
        wire [11:0] cf [3];
        wire signed [25:0] acc;
        for (genvar k = 0; k < 3; k++) begin : g_cf
            wire [11:0] autoCf = (o != k) ? 12'h000 : (o == 0) ? autoR
                               : (o == 2) ? autoB : RST_UNIT[11:0];
            assign cf[k] = awbEn ? autoCf : regs_q[REG_CCM0 + 5'(3 * o + k)][11:0];
        end
        assign acc = 26'($signed(cf[0]) * $signed({1'b0, inCh[0]}))
                   + 26'($signed(cf[1]) * $signed({1'b0, inCh[1]}))
                   + 26'($signed(cf[2]) * $signed({1'b0, inCh[2]}));
        assign ccmOut[o] = acc[25] ? 12'h000
                         : (acc[24:20] != 5'h00) ? 12'hFFF : acc[19:8];
    end
    always_ff @(posedge clk) begin
        if (reset) s6_q <= '0;
        else s6_q <= {s5_q.fv, s5_q.lv, s5_q.vld, ccmOut[0], ccmOut[1], ccmOut[2]};
    end

    // aperture: horizontal high-pass, one pixel of look-ahead
    wire [3:0]  apK = regs_q[REG_APER][3:0];
    wire [11:0] newCh [3];
    assign newCh[0] = s6_q.r;
    assign newCh[1] = s6_q.g;
    assign newCh[2] = s6_q.b;
    logic [11:0] prv_q [3];
    logic [11:0] cur_q [3];
    logic [11:0] apOut [3];
    for (genvar c = 0; c < 3; c++) begin : g_ap
        wire signed [14:0] hp = 15'(2 * cur_q[c]) - 15'(prv_q[c]) - 15'(newCh[c]);
        wire signed [19:0] boost = hp * $signed({1'b0, apK});
        wire signed [15:0] sharp = 16'(cur_q[c]) + 16'(boost >>> 4);
        assign apOut[c] = sharp[15] ? 12'h000 : (sharp[14:12] != 3'b000) ? 12'hFFF
                        : sharp[11:0];
        always_ff @(posedge clk) begin
            if (reset) begin
                prv_q[c] <= 12'h000;
                cur_q[c] <= 12'h000;
            end else if (s6_q.vld) begin
                prv_q[c] <= cur_q[c];
                cur_q[c] <= newCh[c];
            end
        end
    end
    always_ff @(posedge clk) begin
        if (reset) rgbOut <= '0;
        else rgbOut <= {s6_q.fv, s6_q.lv, s6_q.vld, apOut[0], apOut[1], apOut[2]};
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence head_seq;
        sensorIn.vld ##1 s0_q.vld;
    endsequence
    sequence tail_seq;
        s1_q.vld ##1 s2_q.vld ##1 s3_q.vld;
    endsequence
    tp_flat_a: assert property ((tpMode == TP_FLAT && sensorIn.vld) |=>
        s0_q.pix == TP_FLAT_LVL) else $error("flat pattern missing");
    black_clip_a: assert property ((s0_q.vld && s0_q.pix <= black) |=>
        s1_q.pix == 10'h000) else $error("black level not removed");
    shade_ctr_a: assert property ((s1_q.vld && s1_q.col == cx && s1_q.row == cy) |=>
        s2_q.pix == $past(s1_q.pix)) else $error("shading not unity at centre");
    line_win_a: assert property (s3_q.vld |=> win_q[2][4] == $past(s3_q.pix))
        else $error("window row lost");
    defect_fix_a: assert property ((s4_q.vld && atR && defFix) |=>
        s5_q.r == {2'b00, $past(defAvg)}) else $error("defect not replaced");
    ctr_keep_a: assert property ((s4_q.vld && atB) |=>
        s5_q.b == {2'b00, $past(ctrFixed)}) else $error("centre sample lost");
    frame_pipe_a: assert property (head_seq |=> tail_seq)
        else $error("framing misaligned");
    aper_flat_a: assert property ((apK == 4'h0 && s6_q.vld) |=>
        rgbOut.g == $past(cur_q[1])) else $error("aperture altered pixel");
    awb_pick_a: assert property ((fvPrev_q && !s5_q.fv) |=>
        awbWarm_q == $past(sumR_q > sumB_q)) else $error("white balance choice wrong");
endmodule

/* File: tb/rcp_sensor_model.sv */
`timescale 1ns/1ps
module rcp_sensor_model #(
    parameter int W = 32,
    parameter int H = 8
) (
    input  wire logic         clk,
    input  wire logic         go,
    input  wire logic [9:0]   level,
    input  wire logic         hotEn,
    input  wire logic         slow,
    output rcp_pkg::rcp_sensor_t sensorOut,
    output logic              busy
);
    import rcp_pkg::*;

    // outside a pixel strobe the data lines toggle, so no stale sample can be mistaken for data
    task automatic step(input logic [2:0] frm, input logic [9:0] p);
        @(posedge clk);
        sensorOut <= {frm, frm[0] ? p : ~sensorOut.pix};
    endtask

    initial begin
        sensorOut = '0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                repeat (4) step(3'h4, 10'h000);
                for (int r = 0; r < H; r++) begin
                    for (int c = 0; c < W; c++) begin
                        // slow mode leaves a gap cycle before each pixel
                        if (slow) step(3'h6, 10'h000);
                        step(3'h7, (hotEn && r == 4 && c == W / 2) ? 10'h3FF : level);
                    end
                    repeat (6) step(3'h4, 10'h000);
                end
                repeat (16) step(3'h0, 10'h000);
                busy <= 1'b0;
            end
        end
    end
endmodule

/* File: tb/rcp_pipeline_tb.sv */
`timescale 1ns/1ps
module rcp_pipeline_tb;
    import rcp_pkg::*;
    localparam int W = 32;
    localparam int H = 8;
    logic        clk, reset, cyc, stb, we, ack, go, hotEn, slow, checkOn, busy, prevLv;
    logic        nearHot;
    logic [6:0]  adr;
    logic [1:0]  sel;
    logic [15:0] datW, datR, q;
    logic [9:0]  level;
    logic [11:0] expR, expG, expB;
    logic [2:0]  hist [8];
    rcp_sensor_t sensorIn;
    rcp_rgb_t    rgbOut;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          warm = 0;
    int          outCol = 0;
    int          outRow = 0;
    logic [4:0]  idxTab [12] = '{REG_CTRL, REG_BLACK, REG_GAIN, REG_SHX, REG_SHY, REG_DEFTHR,
        REG_EDGETHR, REG_CCM0, REG_CCM0 + 5'h01, REG_CCM0 + 5'h04, REG_APER, 5'h18};
    logic [15:0] rstTab [12] = '{RST_ZERO, RST_ZERO, RST_GAIN, RST_SHX, RST_SHY, RST_THR,
        RST_THR, RST_UNIT, RST_ZERO, RST_UNIT, RST_ZERO, 16'h0000};

    rcp_pipeline dut (.clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
        .sensorIn(sensorIn), .rgbOut(rgbOut));
    rcp_sensor_model #(.W(W), .H(H)) sensorCore (.clk(clk), .go(go), .level(level),
        .hotEn(hotEn), .slow(slow), .sensorOut(sensorIn), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task chk(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task results;
        $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // request held until the edge that samples ack, then released for a cycle
    task wbCycle(input logic w, input logic [4:0] idx, input logic [1:0] s,
                 input logic [15:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        datW <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [4:0] idx, input logic [15:0] d);
        wbCycle(1'b1, idx, 2'b11, d);
    endtask

    task frame;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy !== 1'b0);
    endtask

    // first frame settles line memories and white balance, second is checked
    task runCase(input logic [9:0] lvl, input logic hot, input logic sl,
                 input logic [11:0] r, input logic [11:0] g, input logic [11:0] b, input int id);
        level <= lvl;
        hotEn <= hot;
        slow <= sl;
        expR <= r;
        expG <= g;
        expB <= b;
        frame();
        checkOn <= 1'b1;
        frame();
        checkOn <= 1'b0;
        $display("test %0d done", id);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            results();
        end
    end

    // framing check and interior pixel check; edges of a line depend on padding
    always @(posedge clk) begin
        if (reset) begin
            warm = 0;
        end else begin
            if (warm >= 10) chk({13'h0000, rgbOut.fv, rgbOut.lv, rgbOut.vld}, {13'h0000, hist[7]});
            warm++;
            // neighbours of the hot site see it in their window; only the site itself is checked
            nearHot = hotEn && outRow >= 4 && outRow <= 6 && outCol >= W / 2 + 1
                      && outCol <= W / 2 + 5 && !(outRow == 5 && outCol == W / 2 + 3);
            if (checkOn && rgbOut.vld && outRow >= 3 && outRow <= H - 2 && outCol >= 4
                && outCol <= W - 5 && !nearHot) begin
                chk({4'h0, rgbOut.r}, {4'h0, expR});
                chk({4'h0, rgbOut.g}, {4'h0, expG});
                chk({4'h0, rgbOut.b}, {4'h0, expB});
            end
        end
        outCol = rgbOut.lv ? outCol + int'(rgbOut.vld) : 0;
        if (!rgbOut.fv) outRow = 0;
        else if (prevLv && !rgbOut.lv) outRow++;
        prevLv = rgbOut.lv;
        for (int i = 7; i > 0; i--) hist[i] = hist[i - 1];
        hist[0] = {sensorIn.fv, sensorIn.lv, sensorIn.vld};
    end

    initial begin
        reset = 1'b1;
        {cyc, stb, we, go, hotEn, slow, checkOn, prevLv} = 8'h00;
        adr = 7'h00;
        sel = 2'h0;
        datW = 16'h0000;
        level = 10'h000;
        {expR, expG, expB} = 36'h0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            wbCycle(1'b0, idxTab[i], 2'b11, 16'h0000);
            chk(q, rstTab[i]);
        end
        wr(5'h18, 16'hFFFF);
        wbCycle(1'b0, 5'h18, 2'b11, 16'h0000);
        chk(q, 16'h0000);
        wbCycle(1'b1, REG_GAIN, 2'b01, 16'hAB55);
        wbCycle(1'b0, REG_GAIN, 2'b11, 16'h0000);
        chk(q, 16'h0055);
        wr(REG_GAIN, RST_GAIN);
        $display("test 1 done");
        runCase(10'h155, 1'b0, 1'b1, 12'h155, 12'h155, 12'h155, 2);
        runCase(10'h100, 1'b1, 1'b0, 12'h100, 12'h100, 12'h100, 3);
        wr(REG_CTRL, 16'h0001);
        runCase(10'h000, 1'b0, 1'b0, 12'h200, 12'h200, 12'h200, 4);
        wr(REG_BLACK, 16'h0100);
        wr(REG_GAIN, 16'h00C0);
        runCase(10'h000, 1'b0, 1'b0, 12'h300, 12'h300, 12'h300, 5);
        wr(REG_BLACK, 16'h0000);
        wr(REG_GAIN, RST_GAIN);
        // a far centre saturates the squared distance, so every pixel gets the full factor
        wr(REG_SHX, 16'h07FF);
        for (int i = 0; i < 3; i++) wr(REG_KX0 + 5'(i), 16'h0040);
        runCase(10'h000, 1'b0, 1'b0, 12'h27F, 12'h27F, 12'h27F, 9);
        for (int i = 0; i < 3; i++) wr(REG_KX0 + 5'(i), 16'h0000);
        wr(REG_SHX, RST_SHX);
        wr(REG_CCM0, 16'h0200);
        wr(REG_CCM0 + 5'h01, 16'h0100);
        runCase(10'h000, 1'b0, 1'b0, 12'h600, 12'h200, 12'h200, 6);
        // equal red and blue totals in a flat frame pick the cool matrix
        wr(REG_CTRL, 16'h0005);
        wr(REG_APER, 16'h0004);
        runCase(10'h000, 1'b0, 1'b0, 12'h240, 12'h200, 12'h1C0, 7);
        // fourteen frames so far, last choice cool; status ignores writes
        wr(REG_STATUS, 16'hFFFF);
        wbCycle(1'b0, REG_STATUS, 2'b11, 16'h0000);
        chk(q, 16'h000E);
        wr(REG_CTRL, 16'(TP_RAMP));
        frame();
        wr(REG_CTRL, 16'(TP_CHECK));
        frame();
        $display("test 8 done");
        results();
    end
endmodule
